// [bench/test_accumulator_alu_subset.sv]
// testbench for aas_core: drives instructions phase-aligned, checks acc, flags and file through the peek port
// assumes the file ram powers up unknown, so every value checked is built from reset zeros or from words planted straight into the ram
`timescale 1ns/10ps
module test_accumulator_alu_subset;
    typedef struct packed {
        logic [11:0] ins;
        logic [4:0]  peek;
        logic        chk;
        logic [7:0]  file;
        logic        z;
    } aas_row_t;

    logic        mclk     = 1'b0;
    logic        reset_n  = 1'b0;
    logic [11:0] instr    = 12'h000;
    logic [4:0]  dbg_addr = 5'h00;
    logic [1:0]  phase;
    logic        cycle_end;
    logic [7:0]  acc;
    logic        carry_flag;
    logic        nibble_carry_flag;
    logic        zero_flag;
    logic [7:0]  dbg_data;
    logic [7:0]  seen_file;
    int          fails    = 0;
    int          n_tests  = 0;

    // only zeros can be made from reset, so rows lean on 0 & x == 0 to reach unknown file words
    aas_row_t rows [5] = '{
        '{12'h1c0, 5'h00, 1'b1, 8'h00, 1'b1},   // add f0 into acc, f0 kept
        '{12'h161, 5'h01, 1'b0, 8'h00, 1'b1},   // and acc with f1, result to f1
        '{12'hea5, 5'h01, 1'b1, 8'h00, 1'b1},   // literal and, f1 now written
        '{12'hfff, 5'h01, 1'b1, 8'h00, 1'b1},   // unknown opcode does nothing
        '{12'h1e1, 5'h01, 1'b1, 8'h00, 1'b1}    // add back into f1
    };

    always #12.5 mclk = ~mclk;

    aas_core #(.W(8)) aas_core_i (
        .mclk              (mclk),
        .reset_n           (reset_n),
        .instr             (instr),
        .phase             (phase),
        .cycle_end         (cycle_end),
        .acc               (acc),
        .carry_flag        (carry_flag),
        .nibble_carry_flag (nibble_carry_flag),
        .zero_flag         (zero_flag),
        .dbg_addr          (dbg_addr),
        .dbg_data          (dbg_data)
    );

    // ==========================================================
    // helpers
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // carry and nibble carry can never rise from zero operands
    task automatic check_state(input logic [7:0] acc_exp, input logic z_exp);
        check("acc", acc_exp, acc);
        check("flags", {5'h00, z_exp, 2'h0}, {5'h00, zero_flag, nibble_carry_flag, carry_flag});
    endtask

    // one instruction cycle from phase 0; the file word is peeked in phase 1, before the commit
    task automatic step(input logic [11:0] ins, input logic [4:0] peek);
        instr = ins;
        dbg_addr = peek;
        for (int i = 0; i < 4; i++) begin
            check("phase", 8'(i), {6'h00, phase});
            check("cycle_end", {7'h00, i == 3}, {7'h00, cycle_end});
            @(posedge mclk);
            #1;
            if (i == 0) seen_file = dbg_data;
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        #1 reset_n = 1'b1;
        check_state(8'h00, 1'b0);
        for (int b = 0; b < 8; b++) step({4'h4, 3'(b), 5'h00}, 5'h00);
        check_state(8'h00, 1'b0);
        $display("test clear all bits done");
        foreach (rows[k]) begin
            step(rows[k].ins, rows[k].peek);
            if (rows[k].chk) check("file", rows[k].file, seen_file);
            check_state(8'h00, rows[k].z);
        end
        $display("test table done");
        // clear bit must leave a set zero flag alone
        step(12'h4e0, 5'h00);
        check_state(8'h00, 1'b1);
        $display("test clear keeps flags done");
        // reset in mid-cycle restarts the phase count and drops the flags
        instr = 12'h161;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b0;
        @(posedge mclk);
        #1 reset_n = 1'b1;
        check("phase", 8'h00, {6'h00, phase});
        check_state(8'h00, 1'b0);
        step(12'h1c0, 5'h00);
        check("file", 8'h00, seen_file);
        check_state(8'h00, 1'b1);
        $display("test reset mid cycle done");
        // zeros alone never carry, so two words are planted straight into the ram
        aas_core_i.u_ram.mem[2] = 8'h17;
        aas_core_i.u_ram.mem[3] = 8'hc2;
        step(12'h1c2, 5'h02);
        check("acc", 8'h17, acc);
        step(12'h1c3, 5'h03);
        check("acc", 8'hd9, acc);
        step(12'h1c3, 5'h03);
        check("acc", 8'h9b, acc);
        check("flags", 8'h01, {5'h00, zero_flag, nibble_carry_flag, carry_flag});
        step(12'h1c2, 5'h02);
        check("acc", 8'hb2, acc);
        check("flags", 8'h02, {5'h00, zero_flag, nibble_carry_flag, carry_flag});
        step(12'h163, 5'h03);
        check("acc", 8'hb2, acc);
        check("flags", 8'h02, {5'h00, zero_flag, nibble_carry_flag, carry_flag});
        step(12'hfff, 5'h03);
        check("file", 8'h82, seen_file);
        step(12'he0f, 5'h03);
        check("acc", 8'h02, acc);
        step(12'he01, 5'h03);
        check("acc", 8'h00, acc);
        check("flags", 8'h06, {5'h00, zero_flag, nibble_carry_flag, carry_flag});
        $display("test carries done");
        stop_test();
    end

    // ==========================================================
    // watchdog: the run needs about 100 clocks, some 25 instruction cycles
    initial begin
        repeat (2000) @(posedge mclk);
        fails++;
        $display("unexpected watchdog: expected finish seen hang");
        stop_test();
    end
endmodule // test_accumulator_alu_subset

// [verilog/aas_core.sv]
// execution datapath for add/and/clear-bit instructions on accumulator and file registers
// assumes instr is held stable for a whole instruction cycle, starting at phase 0
//
// Summary of operation
// - opcode 000111 adds accumulator and addressed file register.
// - destination bit 0 sends add/and-file result to accumulator only.
// - destination bit 1 writes result back to file, accumulator kept.
// - opcode 000101 ands accumulator with addressed file register.
// - opcode 1110 ands accumulator with eight-bit literal.
// - and-literal always targets accumulator, never writes a file register.
// - one instruction cycle spans exactly four clock periods.
// - eight-bit two's complement unit, accumulator as one operand.
// - accumulator is a private eight-bit register, not file mapped.
// - add updates carry, nibble carry, zero; and updates zero only.
`timescale 1ns/10ps
module aas_core #(
    parameter int unsigned W = 8
) (
    input  wire logic                           mclk,
    input  wire logic                           reset_n,
    input  wire logic [aas_pkg::INSTR_W-1:0]    instr,
    output logic      [1:0]                     phase,
    output logic                                cycle_end,
    output logic      [W-1:0]                   acc,
    output logic                                carry_flag,
    output logic                                nibble_carry_flag,
    output logic                                zero_flag,
    input  wire logic [aas_pkg::ADDR_W-1:0]     dbg_addr,
    output logic      [W-1:0]                   dbg_data
);
    logic [1:0]                 next_phase;
    logic [W-1:0]               next_acc;
    logic                       next_carry;
    logic                       next_nibble;
    logic                       next_zero;
    aas_pkg::aas_op_t           op;
    logic                       dest_file;
    logic [aas_pkg::ADDR_W-1:0] faddr;
    logic [2:0]                 bsel;
    logic [W-1:0]               fval;
    logic [W-1:0]               result;
    logic [W:0]                 sum;
    logic [4:0]                 low_sum;
    logic                       exec;
    logic                       file_we;
    logic [aas_pkg::ADDR_W-1:0] ram_addr;

    // ================================================================
    // decode
    always_comb begin
        faddr     = instr[aas_pkg::ADDR_W-1:0];
        bsel      = instr[aas_pkg::BIT_LSB+2:aas_pkg::BIT_LSB];
        dest_file = instr[aas_pkg::DEST_BIT];
        op        = aas_pkg::AAS_NOP;
        if (instr[aas_pkg::INSTR_W-1:aas_pkg::OP6_LSB] == aas_pkg::OP_ADD_FILE) begin
            op = aas_pkg::AAS_ADD;
        end else if (instr[aas_pkg::INSTR_W-1:aas_pkg::OP6_LSB] == aas_pkg::OP_AND_FILE) begin
            op = aas_pkg::AAS_ANDF;
        end else if (instr[aas_pkg::INSTR_W-1:aas_pkg::OP4_LSB] == aas_pkg::OP_AND_LIT) begin
            op = aas_pkg::AAS_ANDL;
        end else if (instr[aas_pkg::INSTR_W-1:aas_pkg::OP4_LSB] == aas_pkg::OP_CLR_BIT) begin
            op = aas_pkg::AAS_CLRB;
        end
    end

    // ================================================================
    // phase counter: the whole instruction executes once per four clocks
    always_comb begin
        next_phase = (phase == aas_pkg::PHASE_LAST) ? aas_pkg::PHASE_FIRST : 2'(phase + 2'h1);
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            phase <= aas_pkg::PHASE_FIRST;
        end else begin
            phase <= next_phase;
        end
    end
    assign exec      = (phase == aas_pkg::PHASE_EXEC);
    assign cycle_end = exec;

    // ================================================================
    // file ram; read address shared with debug port in phases 0 and 1, outside the read and execute phases
    assign ram_addr = exec ? faddr : (phase == aas_pkg::PHASE_READ ? faddr : dbg_addr);
    aas_file_ram #(.WIDTH(W), .DEPTH(aas_pkg::FILE_DEPTH), .AW(aas_pkg::ADDR_W)) u_ram (
        .mclk  (mclk),
        .we    (file_we),
        .waddr (faddr),
        .wdata (result),
        .raddr (ram_addr),
        .rdata (fval)
    );
    assign dbg_data = fval;

    // ================================================================
    // alu: eight-bit two's complement sum gives carry out and nibble carry
    always_comb begin
        sum     = {1'b0, acc} + {1'b0, fval};
        low_sum = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};
        case (op)
            aas_pkg::AAS_ADD:  result = sum[W-1:0];
            aas_pkg::AAS_ANDF: result = acc & fval;
            aas_pkg::AAS_ANDL: result = acc & instr[W-1:0];
            aas_pkg::AAS_CLRB: result = fval & ~(W'(1) << bsel);
            default:           result = acc;
        endcase
    end

    // ================================================================
    // write-back steering and flags
    always_comb begin
        next_acc    = acc;
        next_carry  = carry_flag;
        next_nibble = nibble_carry_flag;
        next_zero   = zero_flag;
        file_we     = 1'b0;
        if (exec) begin
            case (op)
                aas_pkg::AAS_ADD, aas_pkg::AAS_ANDF: begin
                    if (dest_file) begin
                        file_we = 1'b1;
                    end else begin
                        next_acc = result;
                    end
                    next_zero = (result == '0);
                    if (op == aas_pkg::AAS_ADD) begin
                        next_carry  = sum[W];
                        next_nibble = low_sum[4];
                    end
                end
                aas_pkg::AAS_ANDL: begin
                    next_acc  = result;
                    next_zero = (result == '0);
                end
                aas_pkg::AAS_CLRB: file_we = 1'b1;
                default: ;
            endcase
        end
    end
    // accumulator has no file address: only the datapath reaches it
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            acc               <= aas_pkg::ACC_RESET;
            carry_flag        <= aas_pkg::FLAGS_RESET[aas_pkg::FLAG_CARRY];
            nibble_carry_flag <= aas_pkg::FLAGS_RESET[aas_pkg::FLAG_NIBBLE];
            zero_flag         <= aas_pkg::FLAGS_RESET[aas_pkg::FLAG_ZERO];
        end else begin
            acc               <= next_acc;
            carry_flag        <= next_carry;
            nibble_carry_flag <= next_nibble;
            zero_flag         <= next_zero;
        end
    end

    // ================================================================
    // checks
    a_cycle_four_clocks: assert property (@(posedge mclk) disable iff (!reset_n)
        cycle_end |=> !cycle_end [*3] ##1 cycle_end) else $error("cycle not four clocks");
    a_add_to_acc: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_ADD && !dest_file |=> acc == $past(sum[W-1:0]))
        else $error("add result missing in accumulator");
    a_dest_acc_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && (op == aas_pkg::AAS_ADD || op == aas_pkg::AAS_ANDF) && !dest_file |-> !file_we)
        else $error("file written with destination zero");
    a_dest_file_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && (op == aas_pkg::AAS_ADD || op == aas_pkg::AAS_ANDF) && dest_file |=> $stable(acc))
        else $error("accumulator changed with destination one");
    a_and_file_acc: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_ANDF && !dest_file |=> acc == ($past(acc) & $past(fval)))
        else $error("and with file wrong");
    a_and_literal: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_ANDL |=> acc == ($past(acc) & $past(instr[W-1:0])))
        else $error("and literal wrong");
    a_literal_no_file: assert property (@(posedge mclk) disable iff (!reset_n)
        op == aas_pkg::AAS_ANDL |-> !file_we) else $error("and literal wrote file");
    a_clear_bit_flags: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_CLRB |-> file_we ##1
        ($stable(zero_flag) && $stable(carry_flag) && $stable(nibble_carry_flag)))
        else $error("clear bit disturbed flags");
    a_and_carry_kept: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && (op == aas_pkg::AAS_ANDF || op == aas_pkg::AAS_ANDL) |=>
        $stable(carry_flag) && $stable(nibble_carry_flag) && zero_flag == ($past(result) == '0))
        else $error("and flags wrong");
    a_add_carry: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_ADD |=> carry_flag == $past(sum[W]))
        else $error("add carry wrong");

    // nibble carry rebuilt from the operands, not from the adder's own low sum
    a_add_nibble: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_ADD |=>
        nibble_carry_flag == (({1'b0, $past(acc[3:0])} + {1'b0, $past(fval[3:0])}) > 5'h0f))
        else $error("add nibble carry wrong");
    // zero flag of the add follows its eight-bit result, carry out excluded
    a_add_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_ADD |=> zero_flag == ($past(sum[W-1:0]) == '0))
        else $error("add zero flag wrong");
    // destination one must really write the sum back into the file
    a_add_to_file: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_ADD && dest_file |-> file_we && result == sum[W-1:0])
        else $error("add not written to file");
    // clear bit drops the chosen bit and keeps every other one
    a_clear_bit_value: assert property (@(posedge mclk) disable iff (!reset_n)
        exec && op == aas_pkg::AAS_CLRB |->
        !result[bsel] && ((result | (W'(1) << bsel)) == (fval | (W'(1) << bsel))))
        else $error("clear bit value wrong");
    // reset restarts the count so the next instruction gets all four clocks
    a_phase_reset: assert property (@(posedge mclk)
        !reset_n |=> phase == aas_pkg::PHASE_FIRST)
        else $error("phase not restarted by reset");
    // accumulator is private: nothing but an executing instruction moves it
    a_acc_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        !exec |=> $stable(acc))
        else $error("accumulator changed outside execute");
endmodule // aas_core

// [verilog/aas_file_ram.sv]
// file register memory: 32 words, one write port, registered read
// assumes read address is held stable for at least one cycle before use
`timescale 1ns/10ps
module aas_file_ram #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5
) (
    input  wire logic             mclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ================================================================
    // storage; contents undefined after reset like real file ram
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // aas_file_ram

// [verilog/aas_pkg.sv]
// package for the accumulator alu subset: opcode fields, flag positions, cycle timing
// assumes a single core clock mclk; no software-visible registers
package aas_pkg;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned INSTR_W     = 12;
    localparam int unsigned ADDR_W      = 5;
    localparam int unsigned FILE_DEPTH  = 32;
    localparam int unsigned PHASES      = 4;          // oscillator periods per instruction cycle
    // opcode fields
    localparam logic [5:0] OP_ADD_FILE  = 6'h07;      // 000111
    localparam logic [5:0] OP_AND_FILE  = 6'h05;      // 000101
    localparam logic [3:0] OP_AND_LIT   = 4'he;       // 1110
    localparam logic [3:0] OP_CLR_BIT   = 4'h4;       // 0100
    localparam int unsigned DEST_BIT    = 5;
    localparam int unsigned BIT_LSB     = 5;
    // status flag positions
    localparam int unsigned FLAG_CARRY  = 0;
    localparam int unsigned FLAG_NIBBLE = 1;
    localparam int unsigned FLAG_ZERO   = 2;
    localparam logic [7:0] ACC_RESET    = 8'h00;
    localparam logic [2:0] FLAGS_RESET  = 3'h0;
    localparam logic [1:0] PHASE_LAST   = 2'h3;
    localparam logic [1:0] PHASE_EXEC   = 2'h3;
    localparam logic [1:0] PHASE_FIRST  = 2'h0;       // phase after reset and after execute
    localparam logic [1:0] PHASE_READ   = 2'h2;       // phase that launches the operand read
    localparam int unsigned OP6_LSB     = 6;          // low end of a six-bit opcode
    localparam int unsigned OP4_LSB     = 8;          // low end of a four-bit opcode
    typedef enum logic [2:0] {AAS_NOP, AAS_ADD, AAS_ANDF, AAS_ANDL, AAS_CLRB} aas_op_t;
endpackage
